// file: common/adcc_regs.vh
// Purpose: register map and field layout of the converter control block
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes:   constants only
`ifndef ADCC_REGS_VH
`define ADCC_REGS_VH

// ==================================================================
// register byte offsets
`define ADCC_OFS_CSR        8'h00
`define ADCC_OFS_RES0       8'h04
`define ADCC_OFS_RES1       8'h08
`define ADCC_OFS_RES2       8'h0c
`define ADCC_OFS_RES3       8'h10
`define ADCC_OFS_IRQ_STAT   8'h14
`define ADCC_OFS_IRQ_MASK   8'h18

// ==================================================================
// control/status field positions
`define ADCC_BIT_END_FLAG   7
`define ADCC_BIT_IRQ_EN     6
`define ADCC_BIT_GO         5
`define ADCC_BIT_SCAN       4
`define ADCC_CH_HI          3
`define ADCC_CH_LO          0

// ==================================================================
// reset values
`define ADCC_RST_CSR        8'h00
`define ADCC_RST_MASK       1'b0

// ==================================================================
// conversion timing: time of one conversion in ns, cycles at 20 MHz
`define ADCC_CONV_NS        13300
`define ADCC_CLK_NS         50
`define ADCC_CONV_CYC       ((`ADCC_CONV_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)

`endif

// file: verilog/adcc_sar_core.v
// Purpose: stand-in successive approximation timing core for one conversion
// Assumes: single clock; sample arrives already digitised on the channel bus
// Notes:   start is a one-cycle pulse, abort drops a conversion at once
`timescale 1ns/100ps

module adcc_sar_core #(
    parameter CONV_CYC = 266,                   // cycles per conversion
    parameter CW       = 9                      // counter width
) (
    input  wire        hclk,                    // system clock
    input  wire        hresetn,                 // async reset, active low
    input  wire        start,                   // begin a conversion
    input  wire        abort,                   // drop the conversion
    input  wire [9:0]  sample,                  // value of the selected input
    output reg         busy_ff,                 // conversion running
    output reg         done_ff,                 // one-cycle end pulse
    output reg  [9:0]  result_ff                // converted value
);

    reg [CW-1:0] cnt_ff;

    // ==================================================================
    // conversion counter
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_ff   <= 1'b0;
            done_ff   <= 1'b0;
            cnt_ff    <= {CW{1'b0}};
            result_ff <= 10'h000;
        end else begin
            done_ff <= 1'b0;
            if (abort) begin
                busy_ff <= 1'b0;
            end else if (start) begin
                busy_ff <= 1'b1;
                cnt_ff  <= CONV_CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
            end else if (busy_ff) begin
                if (cnt_ff == {CW{1'b0}}) begin
                    busy_ff   <= 1'b0;
                    done_ff   <= 1'b1;
                    result_ff <= sample;   // held input taken at the end
                end else begin
                    cnt_ff <= cnt_ff - {{(CW-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule // adcc_sar_core

// file: verilog/adcc_top.v
// Purpose: AHB-Lite control of the twelve-input converter: start, mode, channels
// Assumes: one 20 MHz clock; analog samples arrive as 10-bit synchronous words
// Notes:   results stored left aligned in 16 bits, low six bits zero
`timescale 1ns/100ps
`include "adcc_regs.vh"

module adcc_top #(
    parameter CONV_CYC = `ADCC_CONV_CYC         // cycles per conversion
) (
    input  wire         hclk,                   // system clock
    input  wire         hresetn,                // async reset, active low
    input  wire         hsel,                   // slave select
    input  wire [31:0]  haddr,                  // address
    input  wire [1:0]   htrans,                 // transfer type
    input  wire         hwrite,                 // write strobe
    input  wire [2:0]   hsize,                  // transfer size
    input  wire         hready,                 // bus ready in
    input  wire [31:0]  hwdata,                 // write data
    output reg  [31:0]  hrdata,                 // read data
    output reg          hreadyout,              // ready out
    output reg          hresp,                  // response, always okay
    input  wire [119:0] analog_in,              // 12 x 10-bit input samples
    output reg  [3:0]   conv_sel,               // input now converted
    output reg          conv_busy,              // conversion running
    output reg          conversion_end_irq      // level interrupt
);

    // ==================================================================
    // state machine codes
    localparam S_IDLE = 2'b01;
    localparam S_CONV = 2'b10;

    reg  [1:0]  st_ff;
    reg  [1:0]  nxt_st;
    reg         end_flag_ff;
    reg         irq_en_ff;
    reg         go_ff;
    reg         go_prev_ff;
    reg         scan_ff;
    reg  [3:0]  chan_ff;
    reg  [1:0]  pos_ff;
    reg  [15:0] res_ff [0:3];
    reg         stat_ff;
    reg         mask_ff;
    reg         wr_ph_ff;
    reg         rd_ph_ff;
    reg  [7:0]  addr_ph_ff;
    reg  [9:0]  sample;
    reg  [3:0]  cur_in;
    reg         start_pulse;
    reg         abort_pulse;

    wire        core_busy;
    wire        core_done;
    wire [9:0]  core_res;
    wire        addr_ok;
    wire        last_in;
    wire        sw_go_clear;
    wire [7:0]  csr_val;

    // ==================================================================
    // helper: input index from channel field, mode and position
    function [3:0] input_index;
        input       scan;
        input [3:0] chan;
        input [1:0] pos;
        begin
            if (scan)
                input_index = {chan[3:2], pos};
            else
                input_index = chan;
        end
    endfunction

    // ==================================================================
    // bus address phase capture
    assign addr_ok = hsel & hready & htrans[1];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph_ff   <= 1'b0;
            rd_ph_ff   <= 1'b0;
            addr_ph_ff <= 8'h00;
        end else if (hready) begin
            wr_ph_ff   <= addr_ok & hwrite;
            rd_ph_ff   <= addr_ok & ~hwrite;
            addr_ph_ff <= haddr[7:0];
        end
    end

    wire csr_wr  = wr_ph_ff && (addr_ph_ff == `ADCC_OFS_CSR);
    wire stat_wr = wr_ph_ff && (addr_ph_ff == `ADCC_OFS_IRQ_STAT);
    wire mask_wr = wr_ph_ff && (addr_ph_ff == `ADCC_OFS_IRQ_MASK);
    assign sw_go_clear = csr_wr & ~hwdata[`ADCC_BIT_GO];

    // ==================================================================
    // sequencing: current input and end of the selected set
    always @* begin
        cur_in = input_index(scan_ff, chan_ff, pos_ff);
        sample = analog_in[cur_in*10 +: 10];
    end
    assign last_in = ~scan_ff | (pos_ff == chan_ff[1:0]);

    // ==================================================================
    // control state machine
    always @* begin
        nxt_st      = st_ff;
        start_pulse = 1'b0;
        abort_pulse = 1'b0;
        case (st_ff)
            S_IDLE: begin
                if (go_ff && !go_prev_ff) begin
                    start_pulse = 1'b1;
                    nxt_st      = S_CONV;
                end
            end
            S_CONV: begin
                if (sw_go_clear || !go_ff) begin
                    abort_pulse = 1'b1;
                    nxt_st      = S_IDLE;
                end else if (core_done) begin
                    if (scan_ff)
                        start_pulse = 1'b1;
                    else
                        nxt_st = S_IDLE;
                end
            end
            default: nxt_st = S_IDLE;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            st_ff <= S_IDLE;
        else
            st_ff <= nxt_st;
    end

    // ==================================================================
    // control/status register and sequence position
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            end_flag_ff <= 1'b0;
            irq_en_ff   <= 1'b0;
            go_ff       <= 1'b0;
            go_prev_ff  <= 1'b0;
            scan_ff     <= 1'b0;
            chan_ff     <= 4'h0;
            pos_ff      <= 2'b00;
        end else begin
            go_prev_ff <= go_ff;
            if (csr_wr) begin
                irq_en_ff <= hwdata[`ADCC_BIT_IRQ_EN];
                go_ff     <= hwdata[`ADCC_BIT_GO];
                scan_ff   <= hwdata[`ADCC_BIT_SCAN];
                chan_ff   <= hwdata[`ADCC_CH_HI:`ADCC_CH_LO];
                if (!hwdata[`ADCC_BIT_GO])
                    go_prev_ff <= 1'b0;
            end
            // end flag: write zero clears, a new end wins
            if (csr_wr && !hwdata[`ADCC_BIT_END_FLAG])
                end_flag_ff <= 1'b0;
            if (core_done && last_in && st_ff == S_CONV && !sw_go_clear)
                end_flag_ff <= 1'b1;
            if (st_ff == S_IDLE) begin
                pos_ff <= 2'b00;
            end else if (core_done && !sw_go_clear) begin
                if (last_in) begin
                    pos_ff <= 2'b00;
                    if (!scan_ff)
                        go_ff <= 1'b0;
                end else begin
                    pos_ff <= pos_ff + 2'b01;
                end
            end
        end
    end

    // ==================================================================
    // result registers, chosen by position within the group
    integer i;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (i = 0; i < 4; i = i + 1)
                res_ff[i] <= 16'h0000;
        end else if (core_done && st_ff == S_CONV && !sw_go_clear) begin
            res_ff[cur_in[1:0]] <= {core_res, 6'h00};
        end
    end

    // ==================================================================
    // sticky interrupt status and mask, write one to clear
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_ff <= 1'b0;
            mask_ff <= `ADCC_RST_MASK;
        end else begin
            if (mask_wr)
                mask_ff <= hwdata[0];
            if (core_done && last_in && st_ff == S_CONV && !sw_go_clear)
                stat_ff <= 1'b1;
            else if (stat_wr && hwdata[0])
                stat_ff <= 1'b0;
        end
    end

    // ==================================================================
    // registered outputs
    assign csr_val = {end_flag_ff, irq_en_ff, go_ff, scan_ff, chan_ff};

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata             <= 32'h0000_0000;
            hreadyout          <= 1'b1;
            hresp              <= 1'b0;
            conv_sel           <= 4'h0;
            conv_busy          <= 1'b0;
            conversion_end_irq <= 1'b0;
        end else begin
            conv_sel  <= cur_in;
            conv_busy <= core_busy;
            // either source raises the request, each gated by its own enable
            conversion_end_irq <= (stat_ff & mask_ff) | (end_flag_ff & irq_en_ff);
            hrdata <= 32'h0000_0000;
            if (addr_ok && !hwrite) begin
                case (haddr[7:0])
                    `ADCC_OFS_CSR:      hrdata <= {24'h000000, csr_val};
                    `ADCC_OFS_RES0:     hrdata <= {16'h0000, res_ff[0]};
                    `ADCC_OFS_RES1:     hrdata <= {16'h0000, res_ff[1]};
                    `ADCC_OFS_RES2:     hrdata <= {16'h0000, res_ff[2]};
                    `ADCC_OFS_RES3:     hrdata <= {16'h0000, res_ff[3]};
                    `ADCC_OFS_IRQ_STAT: hrdata <= {31'h00000000, stat_ff};
                    `ADCC_OFS_IRQ_MASK: hrdata <= {31'h00000000, mask_ff};
                    default:            hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ==================================================================
    // conversion timing core
    adcc_sar_core #(
        .CONV_CYC (CONV_CYC),
        .CW       (16)
    ) u_core (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .start     (start_pulse),
        .abort     (abort_pulse),
        .sample    (sample),
        .busy_ff   (core_busy),
        .done_ff   (core_done),
        .result_ff (core_res)
    );

endmodule // adcc_top

// file: tb/adcc_top_asserts.sv
// Purpose: port-level checks of the converter control block
// Assumes: one clock, zero-wait AHB-Lite slave, software avoids codes 12..15
// Notes:   bound into adcc_top below the module
`timescale 1ns/100ps

// ==================================================================
// checker
module adcc_top_asserts #(
    parameter CONV_CYC = 8                      // cycles per conversion
) (
    input wire        hclk,                     // system clock
    input wire        hresetn,                  // async reset, active low
    input wire        hsel,                     // slave select
    input wire [31:0] haddr,                    // address
    input wire [1:0]  htrans,                   // transfer type
    input wire        hwrite,                   // write strobe
    input wire        hready,                   // bus ready
    input wire [31:0] hwdata,                   // write data
    input wire [31:0] hrdata,                   // read data
    input wire        hreadyout,                // ready out
    input wire        hresp,                    // response
    input wire [3:0]  conv_sel,                 // selected input
    input wire        conv_busy,                // converting
    input wire        conversion_end_irq        // level interrupt
);
    wire take = hsel && hready && htrans[1];    // address phase accepted
    reg  dph_wr_ff;                             // write data phase
    reg  dph_csr_ff;                            // control register write data phase
    reg  dph_unm_ff;                            // unmapped read data phase
    reg  dph_res_ff;                            // result read data phase

    // track which data phase is under way
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr_ff  <= 1'b0;
            dph_csr_ff <= 1'b0;
            dph_unm_ff <= 1'b0;
            dph_res_ff <= 1'b0;
        end else begin
            dph_wr_ff  <= take && hwrite;
            dph_csr_ff <= take && hwrite && haddr[7:0] == 8'h00;
            dph_unm_ff <= take && !hwrite && haddr[7:0] > 8'h18;
            dph_res_ff <= take && !hwrite && haddr[7:0] >= 8'h04 && haddr[7:0] <= 8'h10;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_ready; hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("ready out dropped");
    property p_resp; !hresp; endproperty
    a_resp: assert property (p_resp) else $error("error response given");
    property p_abort; dph_csr_ff && !hwdata[5] |-> ##[1:3] !conv_busy; endproperty
    a_abort: assert property (p_abort) else $error("conversion kept after go cleared");
    property p_start; dph_csr_ff && hwdata[5] && !conv_busy |-> ##[1:4] conv_busy; endproperty
    a_start: assert property (p_start) else $error("conversion did not start");
    property p_sel; conv_busy |-> conv_sel < 4'hc; endproperty
    a_sel: assert property (p_sel) else $error("selected input out of range");
    property p_unm; dph_unm_ff |-> hrdata == 32'h0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_res; dph_res_ff |-> hrdata[5:0] == 6'h0 && hrdata[31:16] == 16'h0; endproperty
    a_res: assert property (p_res) else $error("result layout wrong");
    property p_irq;
        $rose(conversion_end_irq) |-> $past(conv_busy, 2) || $past(conv_busy, 3) || $past(conv_busy, 4)
            || $past(dph_wr_ff) || $past(dph_wr_ff, 2);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt without cause");
endmodule // adcc_top_asserts

bind adcc_top adcc_top_asserts #(.CONV_CYC(CONV_CYC)) i_adcc_top_asserts (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .conv_sel, .conv_busy, .conversion_end_irq);

// file: tb/testbench.sv
// Purpose: self-checking bench of the converter control block
// Assumes: zero-wait slave, short conversion count
// Notes:   register access through AHB-Lite single word transfers
`timescale 1ns/100ps
`include "adcc_regs.vh"

// ==================================================================
// bench top
module testbench;
    localparam CC = 8;                          // short conversion
    logic         hclk      = 1'b0;             // clock
    logic         hresetn   = 1'b0;             // reset
    logic [31:0]  haddr     = 32'h0;            // address
    logic [31:0]  hwdata    = 32'h0;            // write data
    logic [1:0]   htrans    = 2'h0;             // transfer type
    logic         hwrite    = 1'b0;             // write strobe
    logic [119:0] analog_in;                    // samples
    logic [31:0]  d;                            // last read
    wire  [31:0]  hrdata;                       // read data
    wire  [3:0]   conv_sel;                     // selected input
    wire          hreadyout, hresp, conv_busy, conversion_end_irq;
    int           fails = 0, num_checks = 0;

    adcc_top #(.CONV_CYC(CC)) i_adcc_top (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .analog_in, .conv_sel,
        .conv_busy, .conversion_end_irq);

    // 20 MHz clock
    always #25 hclk = ~hclk;

    function automatic logic [9:0] smp(input int k);
        return 10'(k * 69 + 37);
    endfunction
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // one single transfer, address phase then data phase
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge hclk);
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        bus(a, 1'b1, wd);
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        chk(n, d, e);
    endtask
    task automatic wt(input logic v);
        do @(negedge hclk); while (conv_busy !== v);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge hclk);
    endtask
    task automatic irq_is(input logic e);
        chk("irq", {31'h0, conversion_end_irq}, {31'h0, e});
    endtask

    task automatic t_reset;
        rdc("csr", `ADCC_OFS_CSR, 32'h0);
        rdc("mask", `ADCC_OFS_IRQ_MASK, 32'h0);
        rdc("unmapped", 8'h40, 32'h0);
        chk("sel", {28'h0, conv_sel}, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_single;
        logic [3:0] chs [4] = '{4'h0, 4'h5, 4'ha, 4'hb}; // only legal codes
        foreach (chs[i]) begin
            wr(`ADCC_OFS_CSR, {24'h0, 4'h2, chs[i]});
            wt(1'b1);
            chk("sel", {28'h0, conv_sel}, {28'h0, chs[i]});
            wt(1'b0);
            cyc(3);
            rdc("csr", `ADCC_OFS_CSR, {24'h0, 4'h8, chs[i]});
            rdc("res", 8'h04 + {4'h0, chs[i][1:0], 2'b00}, {16'h0, smp(chs[i]), 6'h0});
            wr(`ADCC_OFS_CSR, 32'h0);
        end
        $display("test single done");
    endtask
    task automatic t_scan(input logic [3:0] c);
        logic [3:0] prev;
        int         n;
        n = c[1:0] + 1;
        wr(`ADCC_OFS_CSR, {24'h0, 4'h3, c});
        wt(1'b1);
        prev = conv_sel;
        chk("first", {28'h0, prev}, {28'h0, c[3:2], 2'b00});
        for (int i = 1; i <= n; i++) begin
            do @(negedge hclk); while (!(conv_busy === 1'b1 && conv_sel !== prev));
            prev = conv_sel;
            chk("next", {28'h0, prev}, {28'h0, c[3:2], 2'b00} + 32'(i % n));
        end
        rdc("csr run", `ADCC_OFS_CSR, {24'h0, 4'hb, c});
        wr(`ADCC_OFS_CSR, {24'h0, 4'h1, c});
        cyc(3);
        chk("abort", {31'h0, conv_busy}, 32'h0);
        cyc(3 * CC);
        chk("idle", {31'h0, conv_busy}, 32'h0);
        bus(`ADCC_OFS_CSR, 1'b0, 32'h0);
        chk("go", d & 32'h7f, {24'h0, 4'h1, c});
        for (int i = 0; i < n; i++) begin
            rdc("res", 8'(4 + 4 * i), {16'h0, smp(c[3:2] * 4 + i), 6'h0});
        end
        wr(`ADCC_OFS_CSR, 32'h0);
        $display("test scan done");
    endtask
    task automatic t_irq;
        wr(`ADCC_OFS_IRQ_MASK, 32'h1);
        wr(`ADCC_OFS_CSR, 32'h20);
        wt(1'b1);
        wt(1'b0);
        cyc(3);
        irq_is(1'b1);
        rdc("stat", `ADCC_OFS_IRQ_STAT, 32'h1);
        wr(`ADCC_OFS_IRQ_STAT, 32'h1);
        cyc(2);
        irq_is(1'b0);
        wr(`ADCC_OFS_IRQ_MASK, 32'h0);
        wr(`ADCC_OFS_CSR, 32'h60);
        wt(1'b1);
        wt(1'b0);
        cyc(3);
        irq_is(1'b1);
        wr(`ADCC_OFS_CSR, 32'h40);
        cyc(2);
        irq_is(1'b0);
        rdc("stat masked", `ADCC_OFS_IRQ_STAT, 32'h1);
        $display("test irq done");
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // watchdog, far beyond the expected run
    initial begin
        #300000;
        fails++;
        report_and_stop;
    end

    // main sequence
    initial begin
        for (int k = 0; k < 12; k++) begin
            analog_in[10 * k +: 10] = smp(k);
        end
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_single;
        t_scan(4'h6); // channel codes kept below 12
        t_scan(4'hb);
        t_scan(4'h1);
        t_irq;
        report_and_stop;
    end
endmodule // testbench
